//--- common/cfbu_pkg.sv
// constants, types and helpers of the coprocessor flag branch unit
// assumes one core clock domain; flag sources run on that same clock
// Summary of operation
// - target is slot address plus sign-extended offset shifted left two
// - fpu false forms are satisfied when the picked fpu flag is 0
// - fpu true forms are satisfied when the picked fpu flag is 1
// - coprocessor-two false branch is taken when the picked flag is 0
// - non-likely forms always run the slot, redirect only after it
// - likely forms squash the slot when the condition fails
// - condition and displacement in branch step, pc update in slot step
// - four fpu forms decode as one operation with sense and slot-kill bits
// - eight fpu flag bits; the flag pick field chooses one
// - short form encodes flag pick 0, so flag bit 0 is tested
// - raise coprocessor-unusable, reserved-instruction or fpu unimplemented-operation
package cfbu_pkg;

    // ********************************
    // widths and encodings
    // ********************************
    localparam int          REG_WIDTH_DEF = 32;
    localparam int          FLAG_COUNT    = 8;
    localparam int          PICK_W        = 3;
    localparam int          OFFSET_W      = 16;
    localparam int          SHIFT_W       = 2;
    localparam int          INSN_BYTES    = 4;
    localparam logic [5:0]  OP_COP1       = 6'h11;
    localparam logic [5:0]  OP_COP2       = 6'h12;
    localparam logic [4:0]  RS_BRANCH     = 5'h08;

    // ********************************
    // register map, byte addresses
    // ********************************
    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_STATUS    = 5'h04;
    localparam logic [4:0]  REG_MASK      = 5'h08;
    localparam logic [4:0]  REG_TARGET    = 5'h0C;
    localparam logic [4:0]  REG_FLAGS     = 5'h10;
    localparam logic [4:0]  REG_COUNT     = 5'h14;

    // ctrl fields
    localparam int          CTRL_COP1_EN  = 0;
    localparam int          CTRL_COP2_EN  = 1;
    localparam int          CTRL_FP_TRAP  = 2;
    localparam int          CTRL_W        = 3;
    localparam logic [2:0]  CTRL_RESET    = 3'h3;

    // status and mask fields
    localparam int          EV_TAKEN      = 0;
    localparam int          EV_SQUASH     = 1;
    localparam int          EV_EXC        = 2;
    localparam int          EV_W          = 3;
    localparam logic [2:0]  EV_RESET      = 3'h0;

    localparam int          COUNT_W       = 16;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        CFBU_EXC_NONE      = 2'h0,
        CFBU_EXC_UNUSABLE  = 2'h1,
        CFBU_EXC_RESERVED  = 2'h2,
        CFBU_EXC_FP_UNIMPL = 2'h3
    } cfbu_exc_t;

    typedef enum logic [0:0] {
        CFBU_ST_IDLE = 1'h0,
        CFBU_ST_SLOT = 1'h1
    } cfbu_state_t;

    // picks one flag out of eight
    function automatic logic pick_flag(input logic [FLAG_COUNT-1:0] bits,
                                       input logic [PICK_W-1:0]     idx);
        pick_flag = bits[idx];
    endfunction

endpackage

//--- logic/cfbu_flag_file.sv
// forwarding view of the fpu flag bits
// assumes compare strobe, pick and value come from logic on mclk
`timescale 1ns/100ps
module cfbu_flag_file
    import cfbu_pkg::*;
(
    input  wire logic [cfbu_pkg::FLAG_COUNT-1:0] flag_bits,
    input  wire logic                            cmp_we,
    input  wire logic [cfbu_pkg::PICK_W-1:0]     cmp_pick,
    input  wire logic                            cmp_value,
    output logic      [cfbu_pkg::FLAG_COUNT-1:0] live_bits
);

    // ********************************
    // per-bit bypass
    // ********************************
    genvar g;
    generate
        for (g = 0; g < FLAG_COUNT; g++)
        begin : g_bit
            // a compare in this very cycle overrides the stored bit
            assign live_bits[g] = (cmp_we && (cmp_pick == PICK_W'(g))) ?
                                  cmp_value : flag_bits[g];
        end
    endgenerate

endmodule

//--- logic/cfbu_branch_decode.sv
// decode of the coprocessor flag branches and target arithmetic
// assumes instr_pc is the address of the branch itself
`timescale 1ns/100ps
module cfbu_branch_decode
    import cfbu_pkg::*;
#(
    parameter int REG_WIDTH = cfbu_pkg::REG_WIDTH_DEF
)
(
    input  wire logic [31:0]                 instr_word,
    input  wire logic [REG_WIDTH-1:0]        instr_pc,
    output logic                             is_fpu,
    output logic                             is_copro_two,
    output logic                             sense_bit,
    output logic                             slot_kill_bit,
    output logic [cfbu_pkg::PICK_W-1:0]      flag_pick,
    output logic [REG_WIDTH-1:0]             target
);

    logic [5:0]                       opcode;
    logic [4:0]                       sub_op;
    logic [OFFSET_W+SHIFT_W-1:0]      scaled;
    logic [REG_WIDTH-1:0]             disp;
    logic [REG_WIDTH-1:0]             slot_pc;

    assign opcode        = instr_word[31:26];
    assign sub_op        = instr_word[25:21];
    assign is_fpu        = (opcode == OP_COP1) && (sub_op == RS_BRANCH);
    assign is_copro_two  = (opcode == OP_COP2) && (sub_op == RS_BRANCH);
    // one operation, variant fixed by two bits
    assign sense_bit     = instr_word[16];
    assign slot_kill_bit = instr_word[17];
    // short assembler form leaves this field at zero
    assign flag_pick     = instr_word[20:18];

    assign scaled  = {instr_word[OFFSET_W-1:0], {SHIFT_W{1'b0}}};
    assign disp    = {{(REG_WIDTH-OFFSET_W-SHIFT_W){scaled[OFFSET_W+SHIFT_W-1]}},
                      scaled};
    assign slot_pc = instr_pc + REG_WIDTH'(INSN_BYTES);
    assign target  = slot_pc + disp;

endmodule

//--- logic/cfbu_branch_unit.sv
// flag branch unit top with its avalon-mm register slave
// assumes pipeline, fpu and coprocessor-two signals all run on mclk
`timescale 1ns/100ps
module cfbu_branch_unit
    import cfbu_pkg::*;
#(
    parameter int REG_WIDTH = cfbu_pkg::REG_WIDTH_DEF
)
(
    input  wire logic                            mclk,
    input  wire logic                            arst_n,
    input  wire logic [cfbu_pkg::ADDR_W-1:0]     avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [31:0]                     avs_writedata,
    output logic      [31:0]                     avs_readdata,
    output logic                                 avs_waitrequest,
    input  wire logic                            instr_valid,
    input  wire logic [31:0]                     instr_word,
    input  wire logic [REG_WIDTH-1:0]            instr_pc,
    input  wire logic [cfbu_pkg::FLAG_COUNT-1:0] fpu_flag_bits,
    input  wire logic                            fpu_cmp_we,
    input  wire logic [cfbu_pkg::PICK_W-1:0]     fpu_cmp_pick,
    input  wire logic                            fpu_cmp_value,
    input  wire logic [cfbu_pkg::FLAG_COUNT-1:0] copro_two_flag,
    output logic                                 redirect_valid,
    output logic      [REG_WIDTH-1:0]            redirect_pc,
    output logic                                 squash_slot,
    output logic                                 exc_valid,
    output cfbu_pkg::cfbu_exc_t                  exc_code,
    output logic                                 irq
);

    // ********************************
    // decode and flag view
    // ********************************
    logic                      is_fpu;
    logic                      is_copro_two;
    logic                      sense_bit;
    logic                      slot_kill_bit;
    logic [PICK_W-1:0]         flag_pick;
    logic [REG_WIDTH-1:0]      target;
    logic [FLAG_COUNT-1:0]     fpu_flag_line;

    cfbu_branch_decode #(
        .REG_WIDTH     (REG_WIDTH)
    ) u_decode (
        .instr_word    (instr_word),
        .instr_pc      (instr_pc),
        .is_fpu        (is_fpu),
        .is_copro_two  (is_copro_two),
        .sense_bit     (sense_bit),
        .slot_kill_bit (slot_kill_bit),
        .flag_pick     (flag_pick),
        .target        (target)
    );

    cfbu_flag_file u_flags (
        .flag_bits     (fpu_flag_bits),
        .cmp_we        (fpu_cmp_we),
        .cmp_pick      (fpu_cmp_pick),
        .cmp_value     (fpu_cmp_value),
        .live_bits     (fpu_flag_line)
    );

    // ********************************
    // registers of the bus slave
    // ********************************
    logic [CTRL_W-1:0]         ctrl;
    logic [EV_W-1:0]           status;
    logic [EV_W-1:0]           mask;
    logic [REG_WIDTH-1:0]      last_target;
    logic [COUNT_W-1:0]        branch_count;
    logic [EV_W-1:0]           events;
    logic                      count_inc;

    logic [CTRL_W-1:0]         next_ctrl;
    logic [EV_W-1:0]           next_status;
    logic [EV_W-1:0]           next_mask;
    logic [31:0]               next_readdata;
    logic                      next_waitrequest;
    logic                      next_irq;
    logic [COUNT_W-1:0]        next_branch_count;
    logic                      bus_req;
    logic                      bus_accept;
    logic [31:0]               rd_mux;

    assign bus_req    = avs_read || avs_write;
    assign bus_accept = bus_req && !avs_waitrequest;

    always_comb
    begin
        rd_mux = 32'h0;
        unique case (avs_address)
            REG_CTRL:   rd_mux = 32'(ctrl);
            REG_STATUS: rd_mux = 32'(status);
            REG_MASK:   rd_mux = 32'(mask);
            REG_TARGET: rd_mux = 32'(last_target);
            REG_FLAGS:  rd_mux = {16'h0, copro_two_flag, fpu_flag_bits};
            REG_COUNT:  rd_mux = 32'(branch_count);
            default:    ;
        endcase
    end

    always_comb
    begin
        next_ctrl         = ctrl;
        next_mask         = mask;
        next_status       = status;
        next_readdata     = avs_readdata;
        next_branch_count = branch_count + COUNT_W'(count_inc);
        // one wait cycle per request, then release for one cycle
        next_waitrequest  = !(bus_req && avs_waitrequest);
        if (avs_read && avs_waitrequest)
        begin
            next_readdata = rd_mux;
        end
        if (bus_accept && avs_write)
        begin
            unique case (avs_address)
                REG_CTRL:  next_ctrl = avs_writedata[CTRL_W-1:0];
                REG_MASK:  next_mask = avs_writedata[EV_W-1:0];
                REG_COUNT: next_branch_count = COUNT_W'(count_inc);
                default:   ;
            endcase
        end
        // read clears, a new event in the same cycle survives
        if (bus_accept && avs_read && (avs_address == REG_STATUS))
        begin
            next_status = EV_RESET;
        end
        next_status = next_status | events;
        next_irq    = |(next_status & next_mask);
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl            <= CTRL_RESET;
            status          <= EV_RESET;
            mask            <= EV_RESET;
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'b1;
            irq             <= 1'b0;
            branch_count    <= '0;
        end
        else
        begin
            ctrl            <= next_ctrl;
            status          <= next_status;
            mask            <= next_mask;
            avs_readdata    <= next_readdata;
            avs_waitrequest <= next_waitrequest;
            irq             <= next_irq;
            branch_count    <= next_branch_count;
        end
    end

    // ********************************
    // branch resolution
    // ********************************
    cfbu_state_t               state;
    cfbu_state_t               next_state;
    logic                      next_redirect_valid;
    logic [REG_WIDTH-1:0]      next_redirect_pc;
    logic                      next_squash_slot;
    logic                      next_exc_valid;
    cfbu_exc_t                 next_exc_code;
    logic [REG_WIDTH-1:0]      next_last_target;
    logic                      flag_value;
    logic                      cond;
    cfbu_exc_t                 fault;

    always_comb
    begin
        flag_value = is_fpu ? pick_flag(fpu_flag_line, flag_pick)
                            : pick_flag(copro_two_flag, flag_pick);
        // sense 0 wants a clear flag, sense 1 a set flag
        cond = (flag_value == sense_bit);
        fault = CFBU_EXC_NONE;
        if (is_fpu && !ctrl[CTRL_COP1_EN])
        begin
            fault = CFBU_EXC_UNUSABLE;
        end
        else if (is_copro_two && !ctrl[CTRL_COP2_EN])
        begin
            fault = CFBU_EXC_UNUSABLE;
        end
        else if (is_copro_two && (sense_bit || slot_kill_bit))
        begin
            // only the coprocessor-two false form is served here
            fault = CFBU_EXC_RESERVED;
        end
        else if (is_fpu && ctrl[CTRL_FP_TRAP])
        begin
            fault = CFBU_EXC_FP_UNIMPL;
        end
    end

    always_comb
    begin
        next_state          = state;
        next_redirect_valid = redirect_valid;
        next_redirect_pc    = redirect_pc;
        next_squash_slot    = squash_slot;
        next_exc_valid      = 1'b0;
        next_exc_code       = exc_code;
        next_last_target    = last_target;
        events              = EV_RESET;
        count_inc           = 1'b0;
        unique case (state)
            CFBU_ST_IDLE:
            begin
                if (instr_valid && (is_fpu || is_copro_two))
                begin
                    if (fault != CFBU_EXC_NONE)
                    begin
                        next_exc_valid  = 1'b1;
                        next_exc_code   = fault;
                        events[EV_EXC]  = 1'b1;
                    end
                    else
                    begin
                        // resolved now, applied during the slot step
                        next_state          = CFBU_ST_SLOT;
                        next_redirect_valid = cond;
                        next_redirect_pc    = target;
                        next_squash_slot    = slot_kill_bit && !cond;
                        next_last_target    = target;
                        events[EV_TAKEN]    = cond;
                        events[EV_SQUASH]   = slot_kill_bit && !cond;
                        count_inc           = 1'b1;
                    end
                end
            end
            CFBU_ST_SLOT:
            begin
                // slot is never decoded as a branch
                if (instr_valid)
                begin
                    next_state          = CFBU_ST_IDLE;
                    next_redirect_valid = 1'b0;
                    next_squash_slot    = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state          <= CFBU_ST_IDLE;
            redirect_valid <= 1'b0;
            redirect_pc    <= '0;
            squash_slot    <= 1'b0;
            exc_valid      <= 1'b0;
            exc_code       <= CFBU_EXC_NONE;
            last_target    <= '0;
        end
        else
        begin
            state          <= next_state;
            redirect_valid <= next_redirect_valid;
            redirect_pc    <= next_redirect_pc;
            squash_slot    <= next_squash_slot;
            exc_valid      <= next_exc_valid;
            exc_code       <= next_exc_code;
            last_target    <= next_last_target;
        end
    end

endmodule

//--- verification/cfbu_branch_unit_properties.sv
// checker of the flag branch unit, bound to the top module
// assumes one clock mclk and asynchronous reset arst_n
`timescale 1ns/100ps
module cfbu_checker
    import cfbu_pkg::*;
#(
    parameter int REG_WIDTH = cfbu_pkg::REG_WIDTH_DEF
)
(
    input wire logic                  mclk,
    input wire logic                  arst_n,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic                  avs_waitrequest,
    input wire logic                  instr_valid,
    input wire logic [31:0]           instr_word,
    input wire logic [REG_WIDTH-1:0]  instr_pc,
    input wire logic [FLAG_COUNT-1:0] fpu_flag_bits,
    input wire logic                  fpu_cmp_we,
    input wire logic [PICK_W-1:0]     fpu_cmp_pick,
    input wire logic                  fpu_cmp_value,
    input wire logic [FLAG_COUNT-1:0] copro_two_flag,
    input wire logic                  redirect_valid,
    input wire logic [REG_WIDTH-1:0]  redirect_pc,
    input wire logic                  squash_slot,
    input wire logic                  exc_valid,
    input wire cfbu_exc_t             exc_code
);
    logic                 busy;
    logic                 next_busy;
    logic                 accept;
    logic                 cop2;
    logic                 flag;
    logic [REG_WIDTH-1:0] exp_tgt;
    // ********************************
    // branch tracking
    // ********************************
    always_comb
    begin
        cop2 = instr_word[31:26] == OP_COP2;
        accept = instr_valid && (cop2 || instr_word[31:26] == OP_COP1)
            && instr_word[25:21] == RS_BRANCH && (!busy || exc_valid);
        flag = cop2 ? copro_two_flag[instr_word[20:18]]
            : (fpu_cmp_we && fpu_cmp_pick == instr_word[20:18]) ? fpu_cmp_value
            : fpu_flag_bits[instr_word[20:18]];
        exp_tgt = instr_pc + REG_WIDTH'(INSN_BYTES)
            + {{(REG_WIDTH-18){instr_word[15]}}, instr_word[15:0], 2'h0};
        next_busy = accept ? 1'b1 : (instr_valid || exc_valid) ? 1'b0 : busy;
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            busy <= 1'b0;
        else
            busy <= next_busy;
    end
    // ********************************
    // properties
    // ********************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_ok;
        accept ##1 !exc_valid;
    endsequence
    sequence s_wait;
        (redirect_valid || squash_slot) && !instr_valid;
    endsequence
    AST_TARGET: assert property (s_ok |-> !redirect_valid || redirect_pc == $past(exp_tgt))
        else $error("bad target");
    AST_TAKEN: assert property (s_ok |-> redirect_valid == $past(flag == instr_word[16]))
        else $error("bad taken");
    AST_SQUASH: assert property (s_ok |-> squash_slot == $past(flag != instr_word[16] && instr_word[17]))
        else $error("bad squash");
    AST_HOLD: assert property (s_wait |=> $stable({redirect_valid, squash_slot}))
        else $error("early drop");
    AST_DROP: assert property ((redirect_valid || squash_slot) && instr_valid |=> !redirect_valid && !squash_slot)
        else $error("late drop");
    AST_EXCL: assert property (!(redirect_valid && squash_slot))
        else $error("both high");
    AST_EXC: assert property (exc_valid |-> $past(accept) && exc_code != CFBU_EXC_NONE && !redirect_valid)
        else $error("stray exception");
    AST_RSVD: assert property (accept && cop2 && instr_word[17:16] != 2'h0 |=> exc_valid)
        else $error("reserved passed");
    AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("late answer");
    AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
endmodule

bind cfbu_branch_unit cfbu_checker #(.REG_WIDTH(REG_WIDTH)) u_chk (.mclk, .arst_n,
    .avs_read, .avs_write, .avs_waitrequest, .instr_valid, .instr_word, .instr_pc,
    .fpu_flag_bits, .fpu_cmp_we, .fpu_cmp_pick, .fpu_cmp_value, .copro_two_flag,
    .redirect_valid, .redirect_pc, .squash_slot, .exc_valid, .exc_code);

//--- verification/cfbu_flag_model.sv
// model of the fpu and coprocessor-two flag sources
// assumes commands from the bench change just after mclk edges
`timescale 1ns/100ps
module cfbu_flag_model
    import cfbu_pkg::*;
(
    input wire logic   mclk,
    input wire logic   arst_n,
    input wire logic   load_en,
    input wire logic   [7:0] load_fpu,
    input wire logic   [7:0] load_c2,
    input wire logic   cmp_go,
    input wire logic   [2:0] cmp_pick,
    input wire logic   cmp_val,
    output logic       [7:0] fpu_flag_bits,
    output logic       fpu_cmp_we,
    output logic       [2:0] fpu_cmp_pick,
    output logic       fpu_cmp_value,
    output logic       [7:0] copro_two_flag
);
    logic [7:0] next_fpu;
    always_comb
    begin
        next_fpu = load_en ? load_fpu : fpu_flag_bits;
        if (fpu_cmp_we)
            next_fpu[fpu_cmp_pick] = fpu_cmp_value;
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            {fpu_flag_bits, copro_two_flag, fpu_cmp_we, fpu_cmp_pick, fpu_cmp_value} <= '0;
        else
        begin
            fpu_flag_bits <= next_fpu;
            copro_two_flag <= load_en ? load_c2 : copro_two_flag;
            {fpu_cmp_we, fpu_cmp_pick, fpu_cmp_value} <= {cmp_go, cmp_pick, cmp_val};
        end
    end
endmodule

//--- verification/testbench.sv
// self-checking bench of the flag branch unit
// assumes the flag model drives the flag inputs
`timescale 1ns/100ps
module testbench;
    import cfbu_pkg::*;
    typedef struct packed {logic c2; logic kill; logic sense; logic [2:0] pick;
        logic [15:0] off; logic [7:0] fb; logic [7:0] cb; logic [2:0] ctrl;} cfbu_row_t;
    logic mclk, arst_n, avs_read, avs_write, avs_waitrequest, instr_valid, fpu_cmp_we;
    logic fpu_cmp_value, redirect_valid, squash_slot, exc_valid, irq, load_en, cmp_go, cmp_val;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, instr_word, instr_pc, redirect_pc, rd;
    logic [7:0] fpu_flag_bits, copro_two_flag, load_fpu, load_c2;
    logic [2:0] fpu_cmp_pick, cmp_pick;
    cfbu_exc_t exc_code;
    int mismatches, num_checks;
    cfbu_row_t rows [12] = '{'{0,0,0,3'h0,16'h0010,8'hFE,8'h00,3'h3},
        '{0,0,0,3'h3,16'hFFFC,8'h08,8'h00,3'h3}, '{0,1,0,3'h5,16'h0004,8'h20,8'h00,3'h3},
        '{0,1,0,3'h7,16'h7FFF,8'h7F,8'h00,3'h3}, '{0,0,1,3'h1,16'h8000,8'h02,8'h00,3'h3},
        '{0,1,1,3'h2,16'h0020,8'hFB,8'h00,3'h3}, '{1,0,0,3'h2,16'h0100,8'h00,8'hFB,3'h3},
        '{1,0,0,3'h0,16'h0008,8'h00,8'h01,3'h3}, '{1,0,1,3'h1,16'h0008,8'h00,8'h00,3'h3},
        '{1,1,0,3'h1,16'h0008,8'h00,8'h00,3'h3}, '{0,0,0,3'h0,16'h0008,8'h00,8'h00,3'h2},
        '{0,0,1,3'h6,16'h0008,8'h40,8'h00,3'h7}};
    cfbu_branch_unit uut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_pc(instr_pc),
        .fpu_flag_bits(fpu_flag_bits), .fpu_cmp_we(fpu_cmp_we), .fpu_cmp_pick(fpu_cmp_pick),
        .fpu_cmp_value(fpu_cmp_value), .copro_two_flag(copro_two_flag),
        .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .squash_slot(squash_slot),
        .exc_valid(exc_valid), .exc_code(exc_code), .irq(irq));
    cfbu_flag_model u_flags (.mclk(mclk), .arst_n(arst_n), .load_en(load_en),
        .load_fpu(load_fpu), .load_c2(load_c2), .cmp_go(cmp_go), .cmp_pick(cmp_pick),
        .cmp_val(cmp_val), .fpu_flag_bits(fpu_flag_bits), .fpu_cmp_we(fpu_cmp_we),
        .fpu_cmp_pick(fpu_cmp_pick), .fpu_cmp_value(fpu_cmp_value),
        .copro_two_flag(copro_two_flag));
    // ********************************
    // tasks
    // ********************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, wr, !wr, d};
        for (n = 0; n < 16; n++)
        begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
        if (n == 16)
        begin
            mismatches++;
            print_verdict();
        end
    endtask
    // e holds exception code, taken, squashed
    task automatic branch(input logic [31:0] w, input logic [31:0] pc, input logic [3:0] e);
        @(posedge mclk);
        {load_en, cmp_go, instr_valid, instr_word, instr_pc} <= {3'h1, w, pc};
        @(posedge mclk);
        {instr_valid, instr_word, instr_pc} <= {1'b0, 32'h0, pc + 32'h4};
        #1;
        check("redirect_valid", 32'(redirect_valid), 32'(e[1]));
        check("squash_slot", 32'(squash_slot), 32'(e[0]));
        check("exc", 32'({exc_valid, e[3:2] != 2'h0 ? exc_code : e[3:2]}), 32'({e[3:2] != 2'h0, e[3:2]}));
        if (e[1])
            check("redirect_pc", redirect_pc, pc + 32'h4 + {{14{w[15]}}, w[15:0], 2'h0});
        @(posedge mclk) instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        check("window", 32'({redirect_valid, squash_slot, exc_valid}), 32'h0);
    endtask
    // ********************************
    // sequence
    // ********************************
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        {arst_n, avs_read, avs_write, instr_valid, load_en, cmp_go, cmp_val} = '0;
        {avs_address, avs_writedata, instr_word, instr_pc, load_fpu, load_c2, cmp_pick} = '0;
        {mismatches, num_checks} = '0;
        repeat (4) @(posedge mclk);
        #1 check("reset", 32'({avs_waitrequest, redirect_valid, squash_slot, exc_valid, irq}), 32'h10);
        @(posedge mclk) arst_n <= 1'b1;
        bus(0, REG_CTRL, 0); check("ctrl", rd, 32'(CTRL_RESET));
        bus(0, REG_MASK, 0); check("mask", rd, 32'h0);
        bus(1, 5'h18, 32'hFFFFFFFF); bus(0, 5'h18, 0); check("unmapped", rd, 32'h0);
        foreach (rows[i])
        begin
            bus(1, REG_CTRL, 32'(rows[i].ctrl));
            @(posedge mclk);
            {load_en, load_fpu, load_c2} <= {1'b1, rows[i].fb, rows[i].cb};
            branch({rows[i].c2 ? OP_COP2 : OP_COP1, RS_BRANCH, rows[i].pick, rows[i].kill,
                rows[i].sense, rows[i].off}, 32'h0040_0000 + 32'(i) * 32'h40, exp_code(rows[i]));
        end
        check("irq masked", 32'(irq), 32'h0);
        bus(0, REG_STATUS, 0); check("status", rd, 32'h7);
        bus(1, REG_CTRL, 32'h3);
        @(posedge mclk);
        {load_en, load_fpu, cmp_go, cmp_pick, cmp_val} <= {9'h100, 1'b1, 3'h4, 1'b1};
        branch({OP_COP1, RS_BRANCH, 3'h4, 2'h1, 16'hFFF0}, 32'h2000, 4'h2);
        bus(0, REG_FLAGS, 0); check("flags", rd, 32'h10);
        bus(1, REG_TARGET, 0); bus(0, REG_TARGET, 0); check("target", rd, 32'h1FC4);
        bus(0, REG_STATUS, 0); check("status clear", rd, 32'h1);
        bus(1, REG_COUNT, 0); bus(1, REG_MASK, 32'h1);
        branch({OP_COP1, RS_BRANCH, 3'h0, 2'h0, 16'h0004}, 32'h3000, 4'h2);
        check("irq", 32'(irq), 32'h1);
        bus(0, REG_STATUS, 0);
        repeat (2) @(posedge mclk);
        #1 check("irq cleared", 32'(irq), 32'h0);
        bus(0, REG_COUNT, 0); check("count", rd, 32'h1);
        bus(1, REG_CTRL, 0);
        @(posedge mclk) {instr_valid, instr_word} <= {1'b1, OP_COP1, RS_BRANCH, 21'h0};
        @(posedge mclk) {instr_valid, arst_n} <= 2'h0;
        #1 check("mid reset", 32'({avs_waitrequest, redirect_valid, exc_valid}), 32'h4);
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        bus(0, REG_CTRL, 0); check("ctrl again", rd, 32'(CTRL_RESET));
        print_verdict();
    end
    function automatic logic [3:0] exp_code(input cfbu_row_t r);
        logic f;
        logic [1:0] c;
        f = r.c2 ? r.cb[r.pick] : r.fb[r.pick];
        if (r.c2)
            c = !r.ctrl[1] ? 2'h1 : (r.sense || r.kill) ? 2'h2 : 2'h0;
        else
            c = !r.ctrl[0] ? 2'h1 : r.ctrl[2] ? 2'h3 : 2'h0;
        return {c, c == 2'h0 && f == r.sense, c == 2'h0 && f != r.sense && r.kill};
    endfunction
endmodule
